// File: design/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo
   import spi_pkg::*;
(
   input wire logic clk,       // Core clock
   input wire logic rst,       // Async reset
   byte_fifo_if.store port     // Push and pop side
);
   logic [7:0] mem [FIFO_DEPTH];
   logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
   logic [1:0] count, next_count;
   logic do_push, do_pop;

   // Push into a full store is taken only when a pop frees a slot
   always_comb begin
      do_pop = port.pop && (count != 2'h0);
      do_push = port.push && ((count != 2'(FIFO_DEPTH)) || do_pop);
      next_rd_ptr = rd_ptr ^ do_pop;
      next_wr_ptr = wr_ptr ^ do_push;
      next_count = count + 2'(do_push) - 2'(do_pop);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count <= next_count;
      end
   end

   // Data array needs no reset
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= port.wdata;
      end
   end

   assign port.rdata = mem[rd_ptr];
   assign port.full = (count == 2'(FIFO_DEPTH));
   assign port.empty = (count == 2'h0);
endmodule : byte_fifo

// File: design/byte_fifo_if.sv
`timescale 1ns/1ps
interface byte_fifo_if;
   logic push;
   logic pop;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic full;
   logic empty;
   modport user (output push, pop, wdata, input rdata, full, empty);
   modport store (input push, pop, wdata, output rdata, full, empty);
endinterface : byte_fifo_if

// File: design/sclk_divider.sv
`timescale 1ns/1ps
module sclk_divider
   import spi_pkg::*;
(
   input wire logic clk,         // Core clock
   input wire logic rst,         // Async reset
   input wire logic clr,         // Restart the half period
   input wire logic [1:0] rate,  // Rate code
   output logic tick             // One pulse per half period
);
   logic [4:0] cnt, next_cnt;
   logic [5:0] half;

   // Half period doubles with each rate step; six bits hold the 32 of the slowest code
   always_comb begin
      half = {1'b0, SCLK_HALF_BASE} << rate;
      tick = !clr && ({1'b0, cnt} == half - 6'h01);
      next_cnt = (clr || tick) ? 5'h00 : cnt + 5'h01;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 5'h00;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule : sclk_divider

// File: design/spi_pkg.sv
package spi_pkg;
   // ----------------------------------------------------------------
   // Register addresses on the special function register port
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_TX_DATA = 8'h9A;
   localparam logic [7:0] ADDR_RX_DATA = 8'h9B;
   localparam logic [7:0] ADDR_CFG_ONE = 8'hE8;
   localparam logic [7:0] ADDR_CFG_TWO = 8'hE9;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_RX_DATA = 8'h00;
   localparam logic [7:0] RST_CFG_ONE = 8'h10;
   localparam logic [7:0] RST_CFG_TWO = 8'h00;

   // ----------------------------------------------------------------
   // Field positions, config_one_reg
   // ----------------------------------------------------------------
   localparam int IRQ_SRC_BIT = 5;
   localparam int AUTO_SS_BIT = 4;
   localparam int SS_IN_EN_BIT = 3;
   localparam int RX_OVW_BIT = 2;
   localparam int RATE_LSB = 0;

   // ----------------------------------------------------------------
   // Field positions, config_two_reg
   // ----------------------------------------------------------------
   localparam int CONT_BIT = 7;
   localparam int IF_EN_BIT = 6;
   localparam int MASTER_BIT = 4;
   localparam int CPOL_BIT = 3;
   localparam int CPHA_BIT = 2;
   localparam int LSB_FIRST_BIT = 1;

   // ----------------------------------------------------------------
   // Timing counts and sizes
   // ----------------------------------------------------------------
   localparam logic [4:0] SCLK_HALF_BASE = 5'h04;  // Half of divide-by-8
   localparam logic [1:0] STALL_TICKS = 2'h2;      // Idle half periods
   localparam int FIFO_DEPTH = 2;                  // Double buffering

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01,
      ST_STALL = 2'b10
   } xfer_state_e;
endpackage : spi_pkg

// File: design/spi_port.sv
`timescale 1ns/1ps
// Functional notes
// - A read of receive_data_reg moves the receive FIFO head into it; bus bytes enter the FIFO.
// - The interrupt follows receive-full when irq_source_select is 0, transmit-empty when 1.
// - As master with automatic chip select off, SS is held low for manual control.
// - As master with automatic chip select on, SS is low for one byte and then high.
// - With automatic chip select and continuous mode, SS stays low over the whole run.
// - As slave with the SS input enable set, the SS pin selects the slave.
// - With overwrite off, a byte arriving to a full receive buffer is dropped.
// - With overwrite on, a byte arriving to a full receive buffer replaces old data.
// - As master, SCLK is the core clock divided by 8, 16, 32 or 64 per the rate code.
// - Without continuous mode the master stops after each byte, lifts SS when automatic chip select is on, and stalls.
// - In continuous mode the master runs while transmit data waits, SS held until empty.
// - The interface enable bit turns all SPI operation off when 0 and on when 1.
// - The master select bit picks slave when 0 and master when 1.
// - The clock polarity bit sets the SCLK idle level and so the first edge direction.
module spi_port
   import spi_pkg::*;
(
   input wire logic clk,               // Core clock
   input wire logic rst,               // Async reset
   input wire logic [7:0] sfr_addr,    // Register address
   input wire logic sfr_wr,            // Write strobe
   input wire logic sfr_rd,            // Read strobe
   input wire logic [7:0] sfr_wdata,   // Write data
   output logic [7:0] sfr_rdata,       // Read data, next cycle
   input wire logic sclk_i,            // SCLK pin level
   output logic sclk_o,                // SCLK drive
   output logic sclk_oe,               // SCLK enable
   input wire logic mosi_i,            // MOSI pin level
   output logic mosi_o,                // MOSI drive
   output logic mosi_oe,               // MOSI enable
   input wire logic miso_i,            // MISO pin level
   output logic miso_o,                // MISO drive
   output logic miso_oe,               // MISO enable
   input wire logic ss_i,              // SS pin level
   output logic ss_o,                  // SS drive
   output logic ss_oe,                 // SS enable
   output logic irq                    // SPI interrupt level
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_s1, pin_s2;
   logic sclk_d;

   // Order: sclk, mosi, miso, ss
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
         sclk_d <= 1'b0;
      end else begin
         pin_s1 <= {sclk_i, mosi_i, miso_i, ss_i};
         pin_s2 <= pin_s1;
         sclk_d <= pin_s2[3];
      end
   end

   // ----------------------------------------------------------------
   // Registers and FIFOs
   // ----------------------------------------------------------------
   byte_fifo_if tx_f ();
   byte_fifo_if rx_f ();
   byte_fifo u_tx_fifo (.clk(clk), .rst(rst), .port(tx_f.store));
   byte_fifo u_rx_fifo (.clk(clk), .rst(rst), .port(rx_f.store));

   logic [7:0] config_one_reg, next_config_one_reg;
   logic [7:0] config_two_reg, next_config_two_reg;
   logic [7:0] receive_data_reg, next_receive_data_reg;
   logic [7:0] next_sfr_rdata;
   logic sw_rx_read, rx_push, rx_full_drop;
   logic [7:0] rx_byte;

   logic irq_source_select, auto_ss, ss_in_en, rx_overwrite_en;
   logic [1:0] sclk_rate_sel;
   logic continuous_transfer_en, interface_enable, master_select;
   logic clock_polarity, clock_phase, lsb_first, master_on;

   assign irq_source_select = config_one_reg[IRQ_SRC_BIT];
   assign auto_ss = config_one_reg[AUTO_SS_BIT];
   assign ss_in_en = config_one_reg[SS_IN_EN_BIT];
   assign rx_overwrite_en = config_one_reg[RX_OVW_BIT];
   assign sclk_rate_sel = config_one_reg[RATE_LSB +: 2];
   assign continuous_transfer_en = config_two_reg[CONT_BIT];
   assign interface_enable = config_two_reg[IF_EN_BIT];
   assign master_select = config_two_reg[MASTER_BIT];
   assign clock_polarity = config_two_reg[CPOL_BIT];
   assign clock_phase = config_two_reg[CPHA_BIT];
   assign lsb_first = config_two_reg[LSB_FIRST_BIT];
   assign master_on = interface_enable && master_select;

   // Register port: reads answer one cycle after the strobe
   always_comb begin
      next_config_one_reg = config_one_reg;
      next_config_two_reg = config_two_reg;
      next_receive_data_reg = receive_data_reg;
      next_sfr_rdata = 8'h00;
      sw_rx_read = 1'b0;
      tx_f.push = sfr_wr && (sfr_addr == ADDR_TX_DATA);
      tx_f.wdata = sfr_wdata;
      if (sfr_wr && sfr_addr == ADDR_CFG_ONE) begin
         next_config_one_reg = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == ADDR_CFG_TWO) begin
         next_config_two_reg = sfr_wdata;
      end
      if (sfr_rd) begin
         case (sfr_addr)
            ADDR_RX_DATA: begin
               // Empty FIFO leaves the last byte in place
               sw_rx_read = !rx_f.empty;
               next_receive_data_reg = rx_f.empty ? receive_data_reg : rx_f.rdata;
               next_sfr_rdata = next_receive_data_reg;
            end
            ADDR_CFG_ONE: next_sfr_rdata = config_one_reg;
            ADDR_CFG_TWO: next_sfr_rdata = config_two_reg;
            default: next_sfr_rdata = 8'h00;
         endcase
      end
      // Overwrite mode drops the oldest byte to make room
      rx_full_drop = rx_push && rx_f.full && rx_overwrite_en;
      rx_f.pop = sw_rx_read || rx_full_drop;
      rx_f.push = rx_push;  // full store refuses without a pop
      rx_f.wdata = rx_byte;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         config_one_reg <= RST_CFG_ONE;
         config_two_reg <= RST_CFG_TWO;
         receive_data_reg <= RST_RX_DATA;
         sfr_rdata <= 8'h00;
      end else begin
         config_one_reg <= next_config_one_reg;
         config_two_reg <= next_config_two_reg;
         receive_data_reg <= next_receive_data_reg;
         sfr_rdata <= next_sfr_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Transfer engine
   // ----------------------------------------------------------------
   xfer_state_e state, next_state;
   logic [3:0] ecnt, next_ecnt;
   logic [7:0] sh, next_sh, rsh, next_rsh, ld_src, ld_sh;
   logic [1:0] stall, next_stall;
   logic dout, next_dout, next_sclk, next_ss, next_irq;
   logic div_clr, tick, slave_sel, edge_ev, sample, din, load, byte_done;

   sclk_divider u_div (.clk(clk), .rst(rst), .clr(div_clr), .rate(sclk_rate_sel),
      .tick(tick));

   // Without the input enable the slave treats itself as always selected
   assign slave_sel = ss_in_en ? !pin_s2[0] : 1'b1;
   assign din = master_select ? pin_s2[1] : pin_s2[2];

   // Edge source: own divider as master, the far master's SCLK as slave
   always_comb begin
      edge_ev = master_select ? tick : (pin_s2[3] != sclk_d);
      sample = (ecnt[0] == clock_phase);  // Leading edge samples when phase is 0
      ld_src = tx_f.empty ? 8'h00 : tx_f.rdata;
      ld_sh = lsb_first ? {1'b0, ld_src[7:1]} : {ld_src[6:0], 1'b0};
   end

   always_comb begin
      next_state = state;
      next_ecnt = ecnt;
      next_sh = sh;
      next_rsh = rsh;
      next_stall = stall;
      next_dout = dout;
      next_sclk = sclk_o;
      load = 1'b0;
      byte_done = 1'b0;
      rx_push = 1'b0;
      rx_byte = rsh;
      div_clr = 1'b0;
      case (state)
         ST_IDLE: begin
            div_clr = 1'b1;
            next_ecnt = 4'h0;
            next_sclk = clock_polarity;
            if (master_on && !tx_f.empty) begin
               load = 1'b1;
            end else if (interface_enable && !master_select && slave_sel) begin
               load = 1'b1;
            end
         end
         ST_XFER: begin
            if (!interface_enable || (!master_select && !slave_sel)) begin
               next_state = ST_IDLE;
            end else if (edge_ev) begin
               next_ecnt = ecnt + 4'h1;
               if (master_select) begin
                  next_sclk = !sclk_o;
               end
               if (sample) begin
                  next_rsh = lsb_first ? {din, rsh[7:1]} : {rsh[6:0], din};
               end else begin
                  next_dout = lsb_first ? sh[0] : sh[7];
                  next_sh = lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
               end
               if (ecnt == 4'hF) begin
                  byte_done = 1'b1;
                  rx_push = 1'b1;
                  rx_byte = next_rsh;
                  next_ecnt = 4'h0;
                  if (!master_select) begin
                     load = 1'b1;
                  end else if (continuous_transfer_en && !tx_f.empty) begin
                     load = 1'b1;
                  end else begin
                     next_state = ST_STALL;
                     next_stall = 2'h0;
                  end
               end
            end
         end
         ST_STALL: begin
            if (!interface_enable) begin
               next_state = ST_IDLE;
            end else if (tick) begin
               next_stall = stall + 2'h1;
               if (stall == STALL_TICKS - 2'h1) begin
                  next_state = ST_IDLE;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // Phase 0 presents the first bit before the first edge
      if (load) begin
         next_state = ST_XFER;
         next_ecnt = 4'h0;
         next_sh = clock_phase ? ld_src : ld_sh;
         if (!clock_phase) begin
            next_dout = lsb_first ? ld_src[0] : ld_src[7];
         end
      end
      tx_f.pop = load && !tx_f.empty;
      // Manual mode holds SS low; auto mode follows the transfer state
      if (!master_on) begin
         next_ss = 1'b1;
      end else if (!auto_ss) begin
         next_ss = 1'b0;
      end else begin
         next_ss = (next_state != ST_XFER);
      end
      next_irq = interface_enable && (irq_source_select ? tx_f.empty : rx_f.full);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         ecnt <= 4'h0;
         sh <= 8'h00;
         rsh <= 8'h00;
         stall <= 2'h0;
         dout <= 1'b0;
         sclk_o <= 1'b0;
         ss_o <= 1'b1;
         irq <= 1'b0;
         sclk_oe <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         ss_oe <= 1'b0;
      end else begin
         state <= next_state;
         ecnt <= next_ecnt;
         sh <= next_sh;
         rsh <= next_rsh;
         stall <= next_stall;
         dout <= next_dout;
         sclk_o <= next_sclk;
         ss_o <= next_ss;
         irq <= next_irq;
         sclk_oe <= master_on;
         mosi_oe <= master_on;
         miso_oe <= interface_enable && !master_select && slave_sel;
         ss_oe <= master_on;
      end
   end

   // One shift flop serves whichever data pin this end drives
   assign mosi_o = dout;
   assign miso_o = dout;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_half8;
      (!tick) [*3] ##1 tick;
   endsequence

   a_read_moves: assert property (sfr_rd && sfr_addr == ADDR_RX_DATA && !rx_f.empty
      |=> sfr_rdata == $past(rx_f.rdata) && receive_data_reg == sfr_rdata)
      else $error("receive read did not move the FIFO head");
   a_irq_source: assert property (interface_enable && !irq_source_select && rx_f.full
      |=> irq)
      else $error("interrupt missing on full receive buffer");
   a_manual_ss: assert property (master_on && !auto_ss |=> !ss_o)
      else $error("manual chip select not held low");
   a_ss_in_byte: assert property (master_on && auto_ss && state == ST_XFER
      |-> !ss_o)
      else $error("chip select high during a byte");
   a_cont_keep: assert property (master_on && auto_ss && byte_done
      && continuous_transfer_en && !tx_f.empty |=> !ss_o && state == ST_XFER)
      else $error("continuous run released chip select");
   a_rx_discard: assert property (rx_push && rx_f.full && !rx_overwrite_en && !sw_rx_read
      |=> rx_f.full && $stable(rx_f.rdata))
      else $error("full receive buffer accepted a byte");
   a_rx_replace: assert property (rx_push && rx_f.full && rx_overwrite_en && !sw_rx_read
      |=> rx_f.full && rx_f.rdata != $past(rx_f.rdata) || rx_f.rdata == $past(rsh))
      else $error("overwrite did not advance the buffer");
   a_rate_div8: assert property (master_select && state == ST_XFER && tick
      && sclk_rate_sel == 2'h0 && ecnt < 4'hE |=> s_half8)
      else $error("SCLK half period wrong at rate 0");
   a_stop_byte: assert property (master_on && auto_ss && byte_done
      && !continuous_transfer_en |=> ss_o && state == ST_STALL)
      else $error("single byte did not end with stall");
   a_disabled: assert property (!interface_enable |=> state == ST_IDLE)
      else $error("engine active while disabled");
   a_idle_pol: assert property (master_on && state == ST_IDLE ##1 state == ST_IDLE
      |-> sclk_o == $past(clock_polarity))
      else $error("SCLK idle level wrong");
endmodule : spi_port

// File: tb/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
   input wire logic sclk,        // Serial clock from the master
   input wire logic ss_n,        // Chip select, active low
   input wire logic mosi,        // Data from the master
   input wire logic [7:0] resp,  // Byte returned on each frame
   output logic miso,            // Data to the master
   output logic [7:0] got        // Last whole byte taken
);
   logic [7:0] sh_out;
   logic [7:0] sh_in;
   int cnt;
   initial begin
      miso = 1'b0;
      got = 8'h00;
      cnt = 0;
   end
   // First bit must stand before the first edge, so load at select
   always @(negedge ss_n) begin
      cnt = 0;
      sh_out = resp;
      miso = resp[7];
   end
   // Released line shows the inverse, never a stale copy
   always @(posedge ss_n) miso = ~miso;
   // Mode zero: sample on the rising edge, MSB first
   always @(posedge sclk) if (!ss_n) begin
      sh_in = {sh_in[6:0], mosi};
      cnt = cnt + 1;
      if (cnt == 8) begin
         got = sh_in;
         cnt = 0;
      end
   end
   // Shift out on the falling edge; reload between bytes of a run
   always @(negedge sclk) if (!ss_n) begin
      if (cnt == 0) sh_out = resp;
      else sh_out = {sh_out[6:0], 1'b0};
      miso = sh_out[7];
   end
endmodule : spi_slave_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import spi_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata, resp, got;
   logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, irq, miso;
   logic ss_n, sclk_w, mosi_w;
   logic ss_drv = 1'b1;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   // Pins resolve from the enables; undriven SCLK idles low, MOSI idles high, SS follows ss_drv
   assign ss_n = ss_oe ? ss_o : ss_drv;
   assign sclk_w = sclk_oe ? sclk_o : 1'b0;
   assign mosi_w = mosi_oe ? mosi_o : 1'b1;
   always #25 clk = ~clk;
   spi_port dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sclk_i(sclk_w),
      .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o), .miso_oe(miso_oe),
      .ss_i(ss_n), .ss_o(ss_o), .ss_oe(ss_oe), .irq(irq));
   spi_slave_model partner (.sclk(sclk_w), .ss_n(ss_n), .mosi(mosi_w), .resp(resp),
      .miso(miso), .got(got));
   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   // Hang guard sized well above the longest scenario
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         final_report();
      end
   end
   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk) #5;
      sfr_wr = 1'b0;
      // One quiet cycle keeps the strobes of back-to-back calls apart
      @(posedge clk) #5;
   endtask : wr
   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk) #5;
      sfr_rd = 1'b0;
      check(what, sfr_rdata, exp);
      @(posedge clk) #5;
   endtask : rd
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #5;
   endtask : idle
   // Waits for select to fall, returns cycles it stayed low
   task automatic frame(output int low);
      low = 0;
      for (int i = 0; i < 400 && ss_o !== 1'b0; i++) idle(1);
      for (int i = 0; i < 900 && ss_o === 1'b0; i++) begin
         idle(1);
         low++;
      end
      idle(20);
   endtask : frame
   // Cycles between two SCLK toggles in mid-frame
   task automatic half(output int c);
      logic l;
      c = 0;
      for (int i = 0; i < 400 && ss_o !== 1'b0; i++) idle(1);
      idle(3);
      l = sclk_o;
      for (int i = 0; i < 100 && sclk_o === l; i++) idle(1);
      l = sclk_o;
      for (int i = 0; i < 100 && sclk_o === l; i++) begin
         idle(1);
         c++;
      end
   endtask : half
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      resp = 8'h3C;
      idle(4);
      rst = 1'b0;
      rd("rx reset", ADDR_RX_DATA, 8'h00);
      rd("cfg1 reset", ADDR_CFG_ONE, 8'h10);
      rd("cfg2 reset", ADDR_CFG_TWO, 8'h00);
      rd("unmapped", 8'hEA, 8'h00);
      wr(ADDR_CFG_TWO, 8'h10);
      check("off sclk_oe", {7'h00, sclk_oe}, 8'h00);
      check("off ss_oe", {7'h00, ss_oe}, 8'h00);
      $display("test reset done");
      // Single byte, auto select, every rate code
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_CFG_ONE, 8'h10 | r[7:0]);
         wr(ADDR_CFG_TWO, 8'h50);
         resp = 8'h3C + r[7:0];
         wr(ADDR_TX_DATA, 8'hA5 ^ r[7:0]);
         half(n);
         check("half period", n[7:0], 8'h04 << r);
         frame(n);
         check("ss_o idle", {7'h00, ss_o}, 8'h01);
         check("slave got", got, 8'hA5 ^ r[7:0]);
         check("one byte frame", {7'h00, n > 100 * (1 << r)}, 8'h00);
         rd("rx byte", ADDR_RX_DATA, 8'h3C + r[7:0]);
      end
      $display("test rates done");
      // Receive full raises the level interrupt; a read clears it
      wr(ADDR_CFG_ONE, 8'h10);
      for (int i = 0; i < 2; i++) begin
         resp = 8'h11 * (i + 1);
         wr(ADDR_TX_DATA, 8'h00);
         frame(n);
      end
      check("irq rx full", {7'h00, irq}, 8'h01);
      // A third byte to a full buffer is dropped
      resp = 8'h33;
      wr(ADDR_TX_DATA, 8'h00);
      frame(n);
      rd("keep first", ADDR_RX_DATA, 8'h11);
      idle(1);
      check("irq after read", {7'h00, irq}, 8'h00);
      rd("keep second", ADDR_RX_DATA, 8'h22);
      // Overwrite on: newest bytes survive
      wr(ADDR_CFG_ONE, 8'h14);
      for (int i = 0; i < 3; i++) begin
         resp = 8'h44 + i[7:0];
         wr(ADDR_TX_DATA, 8'h00);
         frame(n);
      end
      rd("ovw first", ADDR_RX_DATA, 8'h45);
      rd("ovw second", ADDR_RX_DATA, 8'h46);
      $display("test overflow done");
      // Continuous run: select held across both bytes
      wr(ADDR_CFG_TWO, 8'hD0);
      resp = 8'h5A;
      wr(ADDR_TX_DATA, 8'h01);
      wr(ADDR_TX_DATA, 8'h02);
      frame(n);
      check("cont frame", {7'h00, n > 120 && n < 200}, 8'h01);
      check("cont last", got, 8'h02);
      rd("cont rx1", ADDR_RX_DATA, 8'h5A);
      rd("cont rx2", ADDR_RX_DATA, 8'h5A);
      $display("test continuous done");
      // High polarity parks SCLK high while the master idles
      wr(ADDR_CFG_TWO, 8'h58);
      idle(2);
      check("idle cpol", {7'h00, sclk_o}, 8'h01);
      // Manual select holds SS low; tx empty as interrupt source
      wr(ADDR_CFG_ONE, 8'h20);
      idle(2);
      check("manual ss", {6'h00, ss_oe, ss_o}, 8'h02);
      check("irq tx empty", {7'h00, irq}, 8'h01);
      wr(ADDR_CFG_TWO, 8'h00);
      wr(ADDR_CFG_ONE, 8'h28);
      wr(ADDR_CFG_TWO, 8'h40);
      wr(ADDR_TX_DATA, 8'h77);
      idle(2);
      check("irq tx held", {7'h00, irq}, 8'h00);
      check("slave oe idle", {5'h00, sclk_oe, ss_oe, miso_oe}, 8'h00);
      // Far master selects the slave: it loads the waiting byte and drives MISO
      ss_drv = 1'b0;
      idle(4);
      check("slave selected", {7'h00, miso_oe}, 8'h01);
      check("slave load", {7'h00, irq}, 8'h01);
      ss_drv = 1'b1;
      idle(4);
      check("slave released", {7'h00, miso_oe}, 8'h00);
      $display("test select done");
      final_report();
   end
endmodule : testbench
